// [rtl/rbm_pkg.sv]
// Package for the reset and boot mode select block: constants, modes, timing.
// Assumes a single 100 MHz clock domain and an active-low asynchronous reset.
//
// Functional notes
// - System reset initializes all but test logic.
// - In reset: resets asserted, oscillator runs, PLL off.
// - Test reset clears only factory test logic.
// - Boot select pins captured at reset release.
// - Code 0001: master boot, two-wire ROM port 0.
// - Code 0111: fast asynchronous slave boot.
// - Code 1100: two-wire port 1 slave boot.
// - ROM master boot starts 2650000 ns after release; boot_start is raised only for code 0001, never for SPI ROM code 0010.
package rbm_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;

    localparam int unsigned ROM_BOOT_START_DELAY_NS = 2650000;
    localparam int unsigned ROM_BOOT_START_CYCLES = ROM_BOOT_START_DELAY_NS / CLK_PERIOD_NS;
    localparam int unsigned HOST_BOOT_READY_DELAY_NS = 2400000;
    localparam int unsigned HOST_BOOT_READY_CYCLES =
        (HOST_BOOT_READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned DLY_W = 22;

    localparam logic [3:0] BMS_TWI_ROM = 4'h1;
    localparam logic [3:0] BMS_SPI_ROM = 4'h2;
    localparam logic [3:0] BMS_SPI_SLV = 4'h3;
    localparam logic [3:0] BMS_ASYNC_SLV = 4'h7;
    localparam logic [3:0] BMS_TWI_SLV = 4'hC;

    localparam logic [6:0] TWI_SLAVE_ADDR = 7'h45;
    localparam int unsigned TWI_ROM_KBPS = 400;
    localparam int unsigned ASYNC_KBPS = 384;

    typedef enum logic [2:0] {
        RBM_MODE_NONE,
        RBM_MODE_TWI_ROM,
        RBM_MODE_SPI_ROM,
        RBM_MODE_SPI_SLV,
        RBM_MODE_ASYNC_SLV,
        RBM_MODE_TWI_SLV
    } rbm_mode_e;

    typedef enum logic [1:0] {
        RBM_ST_RESET,
        RBM_ST_WAIT,
        RBM_ST_BOOT
    } rbm_state_e;

    function automatic rbm_mode_e rbm_decode(input logic [3:0] code);
        rbm_mode_e m;
        m = RBM_MODE_NONE;
        case (code)
            BMS_TWI_ROM: m = RBM_MODE_TWI_ROM;
            BMS_SPI_ROM: m = RBM_MODE_SPI_ROM;
            BMS_SPI_SLV: m = RBM_MODE_SPI_SLV;
            BMS_ASYNC_SLV: m = RBM_MODE_ASYNC_SLV;
            BMS_TWI_SLV: m = RBM_MODE_TWI_SLV;
            default: m = RBM_MODE_NONE;
        endcase
        return m;
    endfunction : rbm_decode

endpackage : rbm_pkg

// [rtl/rbm_sync.sv]
// Two-flop synchroniser for a bus of pin levels.
// Assumes clock and rst_b of the receiving domain.
`timescale 1ns/10ps
`default_nettype none
module rbm_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clock,          // Domain clock
    input wire logic rst_b,          // Async reset, active low
    input wire logic [W-1:0] d,      // Raw pin levels
    output logic [W-1:0] q           // Synchronised levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rbm_sync_s;

    rbm_sync_s st_q;
    rbm_sync_s st_d;

    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= {RST_VAL, RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;
endmodule : rbm_sync
`default_nettype wire

// [rtl/rbm_top.sv]
// Reset sequencer and boot mode selector.
// Assumes system_reset_n and test_logic_reset_n are raw pins and boot_select_pins
// are board straps; rst_b is the power-on reset of this clock domain.
`timescale 1ns/10ps
`default_nettype none
module rbm_top
    import rbm_pkg::*;
#(
    parameter int unsigned ROM_START_CYCLES = ROM_BOOT_START_CYCLES,
    parameter int unsigned HOST_READY_CYCLES = HOST_BOOT_READY_CYCLES
) (
    input wire logic clock,                   // 100 MHz clock from crystal
    input wire logic rst_b,                   // Power-on reset, active low
    input wire logic system_reset_n,          // System reset pin
    input wire logic test_logic_reset_n,      // Test reset pin
    input wire logic [3:0] boot_select_pins,  // Boot mode straps
    output logic sys_rst_b,                   // Internal system reset, active low
    output logic test_rst_b,                  // Factory test reset, active low
    output logic osc_en,                      // Crystal oscillator enable
    output logic pll_en,                      // PLL enable
    output logic [3:0] boot_code,             // Captured strap code
    output logic boot_code_valid,             // Strap captured since release
    output logic boot_reserved,               // Captured code is reserved
    output logic twi0_master_en,              // Two-wire port 0 master ROM boot
    output logic spi_master_en,               // SPI master ROM boot
    output logic spi_slave_en,                // SPI slave boot
    output logic async_slave_en,              // Fast async slave boot
    output logic twi1_slave_en,               // Two-wire port 1 slave boot
    output logic [6:0] twi1_slave_addr,       // Slave address on port 1
    output logic boot_start,                  // Start fetching image, level
    output logic host_window_open             // Host may start boot transfer
);
    typedef struct packed {
        logic sys_rst_b;
        logic test_rst_b;
        logic pll_en;
        logic [3:0] code;
        logic valid;
        logic reserved;
        rbm_mode_e mode;
        rbm_state_e state;
        logic [DLY_W-1:0] cnt;
        logic start;
        logic host_ok;
        logic osc_en;
        logic [4:0] mode_en;
        logic [6:0] addr;
    } rbm_top_s;

    rbm_top_s st_q;
    rbm_top_s st_d;
    logic sys_n_s;
    logic trst_n_s;
    logic [3:0] bms_s;

    rbm_sync #(.W(2), .RST_VAL(2'h0)) u_rst_sync (
        .clock(clock),
        .rst_b(rst_b),
        .d({system_reset_n, test_logic_reset_n}),
        .q({sys_n_s, trst_n_s})
    );

    rbm_sync #(.W(4), .RST_VAL(4'hF)) u_bms_sync (
        .clock(clock),
        .rst_b(rst_b),
        .d(boot_select_pins),
        .q(bms_s)
    );

    always_comb begin
        st_d = st_q;
        st_d.test_rst_b = trst_n_s;
        st_d.start = 1'b0;
        case (st_q.state)
            RBM_ST_RESET: begin
                st_d.sys_rst_b = 1'b0;
                st_d.pll_en = 1'b0;
                st_d.cnt = '0;
                st_d.host_ok = 1'b0;
                if (sys_n_s) begin
                    st_d.code = bms_s;
                    st_d.valid = 1'b1;
                    st_d.mode = rbm_decode(bms_s);
                    st_d.reserved = (rbm_decode(bms_s) == RBM_MODE_NONE);
                    st_d.sys_rst_b = 1'b1;
                    st_d.pll_en = 1'b1;
                    st_d.state = RBM_ST_WAIT;
                end
            end
            RBM_ST_WAIT: begin
                st_d.cnt = st_q.cnt + DLY_W'(1);
                if (st_q.cnt == DLY_W'(HOST_READY_CYCLES - 1)) begin
                    st_d.host_ok = 1'b1;
                end
                if (st_q.cnt == DLY_W'(ROM_START_CYCLES - 1)) begin
                    st_d.start = (st_q.mode == RBM_MODE_TWI_ROM);
                    st_d.state = RBM_ST_BOOT;
                end
            end
            RBM_ST_BOOT: begin
                st_d.start = (st_q.mode == RBM_MODE_TWI_ROM);
                st_d.host_ok = 1'b1;
            end
            default: st_d.state = RBM_ST_RESET;
        endcase
        if (!sys_n_s) begin
            st_d.sys_rst_b = 1'b0;
            st_d.pll_en = 1'b0;
            st_d.valid = 1'b0;
            st_d.start = 1'b0;
            st_d.host_ok = 1'b0;
            st_d.cnt = '0;
            st_d.state = RBM_ST_RESET;
        end
        // Oscillator keeps running through system reset
        st_d.osc_en = 1'b1;
        st_d.addr = TWI_SLAVE_ADDR;
        // Mode enables registered from the next code state so outputs stay flops
        st_d.mode_en = '0;
        if (st_d.valid) begin
            st_d.mode_en = {st_d.mode == RBM_MODE_TWI_ROM,
                            st_d.mode == RBM_MODE_SPI_ROM,
                            st_d.mode == RBM_MODE_SPI_SLV,
                            st_d.mode == RBM_MODE_ASYNC_SLV,
                            st_d.mode == RBM_MODE_TWI_SLV};
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '{sys_rst_b: 1'b0, test_rst_b: 1'b0, pll_en: 1'b0, code: 4'h0,
                      valid: 1'b0, reserved: 1'b0, mode: RBM_MODE_NONE,
                      state: RBM_ST_RESET, cnt: '0, start: 1'b0, host_ok: 1'b0,
                      osc_en: 1'b1, mode_en: 5'h00, addr: TWI_SLAVE_ADDR};
        end else begin
            st_q <= st_d;
        end
    end

    assign sys_rst_b = st_q.sys_rst_b;
    assign test_rst_b = st_q.test_rst_b;
    assign osc_en = st_q.osc_en;
    assign pll_en = st_q.pll_en;
    assign boot_code = st_q.code;
    assign boot_code_valid = st_q.valid;
    assign boot_reserved = st_q.reserved;
    assign twi0_master_en = st_q.mode_en[4];
    assign spi_master_en = st_q.mode_en[3];
    assign spi_slave_en = st_q.mode_en[2];
    assign async_slave_en = st_q.mode_en[1];
    assign twi1_slave_en = st_q.mode_en[0];
    assign twi1_slave_addr = st_q.addr;
    assign boot_start = st_q.start;
    assign host_window_open = st_q.host_ok;

    AST_RST_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
        !sys_n_s |=> !sys_rst_b && !pll_en)
        else $error("System reset not held");

    AST_PLL_OFF: assert property (@(posedge clock) disable iff (!rst_b)
        !sys_rst_b |-> !pll_en)
        else $error("PLL enabled during reset");

    AST_TEST_ONLY: assert property (@(posedge clock) disable iff (!rst_b)
        sys_rst_b && $fell(test_rst_b) && sys_n_s |=> sys_rst_b && pll_en)
        else $error("Test reset disturbed system");

    sequence rel_s;
        !sys_rst_b ##1 sys_rst_b;
    endsequence

    AST_CAPTURE: assert property (@(posedge clock) disable iff (!rst_b)
        rel_s |-> boot_code_valid && boot_code == $past(bms_s))
        else $error("Boot code not captured at release");

    AST_STABLE: assert property (@(posedge clock) disable iff (!rst_b)
        boot_code_valid && $past(boot_code_valid) |-> $stable(boot_code))
        else $error("Boot code changed after capture");

    AST_TWI0: assert property (@(posedge clock) disable iff (!rst_b)
        boot_code_valid && boot_code == BMS_TWI_ROM |-> twi0_master_en && !spi_master_en)
        else $error("Two-wire ROM mode wrong");

    AST_SPI: assert property (@(posedge clock) disable iff (!rst_b)
        boot_code_valid && boot_code == BMS_SPI_SLV |-> spi_slave_en && !spi_master_en)
        else $error("SPI mode wrong");

    AST_ASYNC: assert property (@(posedge clock) disable iff (!rst_b)
        async_slave_en |-> boot_code == BMS_ASYNC_SLV)
        else $error("Async slave mode wrong");

    AST_TWI1: assert property (@(posedge clock) disable iff (!rst_b)
        twi1_slave_en |-> boot_code == BMS_TWI_SLV && twi1_slave_addr == 7'h45)
        else $error("Two-wire slave mode wrong");

    AST_START: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(boot_start) |-> twi0_master_en && $past(st_q.cnt) == DLY_W'(ROM_START_CYCLES - 1))
        else $error("ROM boot start timing wrong");
endmodule : rbm_top
`default_nettype wire

// [sim/rbm_board.sv]
// Board model: reset pins and boot straps of the block.
// Assumes the bench asks for reset and straps; pins change at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module rbm_board (
    input wire logic clock,              // Bench clock
    input wire logic hold_rst,           // Hold system reset
    input wire logic trst_only,          // Pulse test reset alone
    input wire logic strap_float,        // Straps left open
    input wire logic [3:0] strap,        // Strapped code
    output logic system_reset_n = 1'b0,  // System reset pin
    output logic test_logic_reset_n = 1'b0, // Test reset pin
    output logic [3:0] boot_select_pins = 4'hF // Strap pins
);
    always @(negedge clock) begin
        system_reset_n <= !hold_rst;
        test_logic_reset_n <= !(hold_rst || trst_only);
        // Open straps read as the pull-up level
        boot_select_pins <= strap_float ? 4'hF : strap;
    end
endmodule : rbm_board
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the reset sequencer and boot mode selector.
// Assumes short sim delays; the board model drives pins, the bench rst_b.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import rbm_pkg::*;
    localparam int unsigned ROM_N = 20;
    localparam int unsigned HOST_N = 16;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic hold_rst = 1'b1;
    logic trst_only = 1'b0;
    logic strap_float = 1'b0;
    logic [3:0] strap = 4'h1;
    wire logic system_reset_n;
    wire logic test_logic_reset_n;
    wire logic [3:0] boot_select_pins;
    logic sys_rst_b, test_rst_b, osc_en, pll_en, boot_code_valid, boot_reserved;
    logic twi0_master_en, spi_master_en, spi_slave_en, async_slave_en, twi1_slave_en;
    logic boot_start, host_window_open;
    logic [3:0] boot_code;
    logic [6:0] twi1_slave_addr;
    int err_total = 0;
    int checked = 0;
    rbm_board rbm_board_i (.clock(clock), .hold_rst(hold_rst), .trst_only(trst_only),
        .strap_float(strap_float), .strap(strap), .system_reset_n(system_reset_n),
        .test_logic_reset_n(test_logic_reset_n), .boot_select_pins(boot_select_pins));
    rbm_top #(.ROM_START_CYCLES(ROM_N), .HOST_READY_CYCLES(HOST_N)) rbm_top_i (
        .clock(clock), .rst_b(rst_b), .system_reset_n(system_reset_n),
        .test_logic_reset_n(test_logic_reset_n), .boot_select_pins(boot_select_pins),
        .sys_rst_b(sys_rst_b), .test_rst_b(test_rst_b), .osc_en(osc_en), .pll_en(pll_en),
        .boot_code(boot_code), .boot_code_valid(boot_code_valid),
        .boot_reserved(boot_reserved), .twi0_master_en(twi0_master_en),
        .spi_master_en(spi_master_en), .spi_slave_en(spi_slave_en),
        .async_slave_en(async_slave_en), .twi1_slave_en(twi1_slave_en),
        .twi1_slave_addr(twi1_slave_addr), .boot_start(boot_start),
        .host_window_open(host_window_open));
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    // Reset with a strap, check the held state, release and wait for capture
    task automatic t_reset(input logic [3:0] code, input logic fl);
        @(negedge clock);
        strap = code;
        strap_float = fl;
        hold_rst = 1'b1;
        repeat (6) @(negedge clock);
        chk("sys_rst_b held", 8'h00, {7'h00, sys_rst_b});
        chk("pll osc test in reset", 8'h04, {5'h00, osc_en, pll_en, test_rst_b});
        hold_rst = 1'b0;
        for (int i = 0; i < 10 && sys_rst_b !== 1'b1; i++) @(negedge clock);
        chk("sys_rst_b released", 8'h01, {7'h00, sys_rst_b});
        chk("pll_en released", 8'h01, {7'h00, pll_en});
    endtask : t_reset
    task automatic t_modes();
        logic [3:0] codes [5] = '{4'h1, 4'h2, 4'h3, 4'h7, 4'hC};
        for (int k = 0; k < 5; k++) begin
            t_reset(codes[k], 1'b0);
            chk("boot_code", {4'h0, codes[k]}, {4'h0, boot_code});
            chk("valid reserved", 8'h02, {6'h00, boot_code_valid, boot_reserved});
            chk("mode enables", 8'h01 << (4 - k), {3'h0, twi0_master_en, spi_master_en,
                spi_slave_en, async_slave_en, twi1_slave_en});
        end
        chk("twi1_slave_addr", 8'h45, {1'b0, twi1_slave_addr});
    endtask : t_modes
    task automatic t_reserved();
        logic [3:0] codes [8] = '{4'h0, 4'h8, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE, 4'hF};
        for (int k = 0; k < 9; k++) begin
            t_reset(k < 8 ? codes[k] : 4'h1, k == 8);
            chk("reserved flag", 8'h01, {7'h00, boot_reserved});
            chk("no mode", 8'h00, {3'h0, twi0_master_en, spi_master_en, spi_slave_en,
                async_slave_en, twi1_slave_en});
        end
    endtask : t_reserved
    // Strap change after capture and a lone test reset must leave the code
    task automatic t_hold_trst();
        t_reset(4'h7, 1'b0);
        strap = 4'h2;
        trst_only = 1'b1;
        repeat (6) @(negedge clock);
        chk("test_rst_b", 8'h00, {7'h00, test_rst_b});
        chk("sys kept", 8'h03, {6'h00, sys_rst_b, pll_en});
        chk("code kept", 8'h07, {4'h0, boot_code});
        trst_only = 1'b0;
        repeat (6) @(negedge clock);
        chk("test_rst_b back", 8'h01, {7'h00, test_rst_b});
    endtask : t_hold_trst
    task automatic t_timing(input logic [3:0] code);
        int n;
        int hw;
        int bs;
        hw = -1;
        bs = -1;
        t_reset(code, 1'b0);
        for (n = 0; n < ROM_N + 8; n++) begin
            if (hw < 0 && host_window_open === 1'b1) hw = n;
            if (bs < 0 && boot_start === 1'b1) bs = n;
            @(negedge clock);
        end
        chk("host window near", 8'h01, {7'h00, hw >= HOST_N - 1 && hw <= HOST_N + 1});
        if (code == 4'h1)
            chk("rom start near", 8'h01, {7'h00, bs >= ROM_N - 1 && bs <= ROM_N + 1});
        else
            chk("no rom start", 8'h01, {7'h00, bs < 0});
    endtask : t_timing
    initial begin
        repeat (20) @(negedge clock);
        rst_b = 1'b1;
        t_modes();
        t_reserved();
        t_hold_trst();
        t_timing(4'h1);
        t_timing(4'hC);
        summarize();
    end
    initial begin
        #100us;
        err_total++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
